// >>> src/fcs_regs.svh
`ifndef FCS_REGS_SVH
`define FCS_REGS_SVH

// Clock and bus cycle timing, in ns and in derived cycles
`define FCS_CLK_NS       10
`define FCS_T_SETUP_NS   20
`define FCS_T_WE_NS      40
`define FCS_T_OE_NS      100
`define FCS_T_HOLD_NS    20
`define FCS_CYC(ns)      (((ns) + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_SETUP_CYC    `FCS_CYC(`FCS_T_SETUP_NS)
`define FCS_WE_CYC       `FCS_CYC(`FCS_T_WE_NS)
`define FCS_RD_CYC       (`FCS_CYC(`FCS_T_OE_NS) + 2)
`define FCS_HOLD_CYC     `FCS_CYC(`FCS_T_HOLD_NS)

// Unlock and query addresses, word and byte mode
`define FCS_UNLOCK1_WORD 24'h000555
`define FCS_UNLOCK2_WORD 24'h0002AA
`define FCS_UNLOCK1_BYTE 24'h000AAA
`define FCS_UNLOCK2_BYTE 24'h000555
`define FCS_CFI_WORD     24'h000055
`define FCS_CFI_BYTE     24'h0000AA
`define FCS_ANY_ADDR     24'h000000

// Command data values
`define FCS_D_UNLOCK1    16'h00AA
`define FCS_D_UNLOCK2    16'h0055
`define FCS_D_RESET      16'h00F0
`define FCS_D_AUTOSEL    16'h0090
`define FCS_D_SECURE     16'h0088
`define FCS_D_EXIT       16'h0000
`define FCS_D_PROGRAM    16'h00A0
`define FCS_D_BUFLOAD    16'h0025
`define FCS_D_BUFCONF    16'h0029
`define FCS_D_ERASE      16'h0080
`define FCS_D_CHIP       16'h0010
`define FCS_D_SECTOR     16'h0030
`define FCS_D_CFI        16'h0098
`define FCS_D_SUSPEND    16'h00B0
`define FCS_D_RESUME     16'h0030

// Identification read offsets, word then byte mode
`define FCS_ID_MAKER_W   8'h00
`define FCS_ID_DEV1_W    8'h01
`define FCS_ID_DEV2_W    8'h0E
`define FCS_ID_DEV3_W    8'h0F
`define FCS_ID_FLOCK_W   8'h03
`define FCS_ID_PROT_W    8'h02
`define FCS_ID_MAKER_B   8'h00
`define FCS_ID_DEV1_B    8'h02
`define FCS_ID_DEV2_B    8'h1C
`define FCS_ID_DEV3_B    8'h1E
`define FCS_ID_FLOCK_B   8'h06
`define FCS_ID_PROT_B    8'h04

`endif

// >>> src/fcs_pkg.sv
package fcs_pkg;

  typedef enum logic [3:0] {
    CMD_RESET      = 4'h0,
    CMD_ID_ENTRY   = 4'h1,
    CMD_SEC_ENTRY  = 4'h2,
    CMD_SEC_EXIT   = 4'h3,
    CMD_PROGRAM    = 4'h4,
    CMD_BUF_PROG   = 4'h5,
    CMD_BUF_ABORT  = 4'h6,
    CMD_CHIP_ERASE = 4'h7,
    CMD_SECT_ERASE = 4'h8,
    CMD_CFI        = 4'h9,
    CMD_SUSPEND    = 4'hA,
    CMD_RESUME     = 4'hB,
    CMD_READ       = 4'hC,
    CMD_ID_READ    = 4'hD
  } fcs_cmd_t;

  // Where a bus cycle takes its address and data from
  typedef enum logic [3:0] {
    K_U1     = 4'h0,
    K_U2     = 4'h1,
    K_CMD1   = 4'h2,
    K_ANY    = 4'h3,
    K_SECT   = 4'h4,
    K_COUNT  = 4'h5,
    K_TARGET = 4'h6,
    K_STREAM = 4'h7,
    K_READ   = 4'h8,
    K_CFI    = 4'h9
  } fcs_kind_t;

  typedef struct packed {
    fcs_kind_t   kind;
    logic [15:0] data;
    logic        last;
  } fcs_cycle_t;

  typedef struct packed {
    fcs_cmd_t    cmd;
    logic        byte_mode;
    logic [23:0] addr;
    logic [15:0] data;
    logic [4:0]  count;
  } fcs_req_t;

  typedef struct packed {
    logic        read;
    logic        byte_mode;
    logic [23:0] addr;
    logic [15:0] data;
  } fcs_bus_req_t;

  typedef struct packed {
    logic        reset_n;
    logic        ce_n;
    logic        we_n;
    logic        oe_n;
    logic        byte_n;
    logic [22:0] addr;
    logic [15:0] dq_out;
    logic [15:0] dq_oe;
  } fcs_pins_t;

  typedef enum logic [3:0] {
    B_IDLE  = 4'h1,
    B_SETUP = 4'h2,
    B_PULSE = 4'h4,
    B_HOLD  = 4'h8
  } fcs_bus_st_t;

  typedef struct packed {
    fcs_bus_st_t  st;
    fcs_bus_req_t req;
    logic [7:0]   cnt;
    logic [15:0]  sync1;
    logic [15:0]  sync2;
    fcs_pins_t    pins;
    logic         done;
    logic [15:0]  rd_data;
  } fcs_bus_state_t;

  typedef enum logic [2:0] {
    M_IDLE  = 3'h1,
    M_ISSUE = 3'h2,
    M_WAIT  = 3'h4
  } fcs_main_st_t;

  typedef struct packed {
    fcs_main_st_t st;
    fcs_cmd_t     cmd;
    logic         byte_mode;
    logic [23:0]  addr;
    logic [15:0]  data;
    logic [4:0]   count;
    logic [4:0]   left;
    logic [2:0]   idx;
    logic         rsp_valid;
    logic [15:0]  rsp_data;
  } fcs_main_state_t;

endpackage

// >>> src/fcs_bus_cycle.sv
`timescale 1ns/1ps
`include "fcs_regs.svh"

module fcs_bus_cycle (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 start,
  input  fcs_pkg::fcs_bus_req_t     req,
  output logic                      idle,
  output logic                      done,
  output logic [15:0]               rd_data,
  output fcs_pkg::fcs_pins_t        pins,
  input  wire logic [15:0]          dq_in
);

  fcs_pkg::fcs_bus_state_t s;
  fcs_pkg::fcs_bus_state_t next_s;

  assign idle    = (s.st == fcs_pkg::B_IDLE);
  assign done    = s.done;
  assign rd_data = s.rd_data;
  assign pins    = s.pins;

  // One strobed cycle: setup, pulse, hold, all with chip enable low
  always_comb begin
    next_s              = s;
    next_s.done         = 1'b0;
    next_s.pins.reset_n = 1'b1;
    // Pin data is asynchronous to clk, so two stages before use
    next_s.sync1        = dq_in;
    next_s.sync2        = s.sync1;
    case (s.st)
      fcs_pkg::B_IDLE: begin
        if (start) begin
          next_s.req         = req;
          next_s.st          = fcs_pkg::B_SETUP;
          next_s.cnt         = 8'(`FCS_SETUP_CYC - 1);
          next_s.pins.ce_n   = 1'b0;
          next_s.pins.byte_n = ~req.byte_mode;
          // Byte mode moves the address down one pin; A-1 rides on DQ15
          if (req.byte_mode) begin
            next_s.pins.addr   = req.addr[23:1];
            next_s.pins.dq_out = {req.addr[0], 7'h00, req.data[7:0]};
            next_s.pins.dq_oe  = req.read ? 16'h8000 : 16'h80FF;
          end else begin
            next_s.pins.addr   = req.addr[22:0];
            next_s.pins.dq_out = req.data;
            next_s.pins.dq_oe  = req.read ? 16'h0000 : 16'hFFFF;
          end
        end
      end
      fcs_pkg::B_SETUP: begin
        if (s.cnt == 8'h00) begin
          next_s.st        = fcs_pkg::B_PULSE;
          next_s.cnt       = s.req.read ? 8'(`FCS_RD_CYC - 1) : 8'(`FCS_WE_CYC - 1);
          next_s.pins.we_n = s.req.read;
          next_s.pins.oe_n = ~s.req.read;
        end else begin
          next_s.cnt = s.cnt - 8'h01;
        end
      end
      fcs_pkg::B_PULSE: begin
        if (s.cnt == 8'h00) begin
          // Read pulse already covers access time plus sync delay
          if (s.req.read) begin
            next_s.rd_data = s.req.byte_mode ? {8'h00, s.sync2[7:0]} : s.sync2;
          end
          next_s.st        = fcs_pkg::B_HOLD;
          next_s.cnt       = 8'(`FCS_HOLD_CYC - 1);
          next_s.pins.we_n = 1'b1;
          next_s.pins.oe_n = 1'b1;
        end else begin
          next_s.cnt = s.cnt - 8'h01;
        end
      end
      fcs_pkg::B_HOLD: begin
        if (s.cnt == 8'h00) begin
          next_s.st         = fcs_pkg::B_IDLE;
          next_s.pins.ce_n  = 1'b1;
          next_s.pins.dq_oe = 16'h0000;
          next_s.done       = 1'b1;
        end else begin
          next_s.cnt = s.cnt - 8'h01;
        end
      end
      default: begin
        next_s.st = fcs_pkg::B_IDLE;
      end
    endcase
  end

  // Flash held in hardware reset while this block is in reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s           <= '0;
      s.st        <= fcs_pkg::B_IDLE;
      s.pins.ce_n <= 1'b1;
      s.pins.we_n <= 1'b1;
      s.pins.oe_n <= 1'b1;
      s.pins.byte_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

endmodule

// >>> src/fcs_host.sv
// Operation
// - One write of F0 anywhere returns the flash to array read.
// - Commands open with AA to 555, 55 to 2AA; byte mode AAA, 555.
// - Unlock then 90 enters identification; ID words at fixed low offsets.
// - Unlock then 88 maps security region; unlock, 90, 00 exits it.
// - Single program: unlock pair, A0 to 555, then data to target.
// - Buffered program: unlock, 25 to sector, then word count minus one.
// - Then each buffer word goes to its address until the count is loaded.
// - Confirm with 29 to the sector address to program the buffer.
// - Unlock pair then F0 to 555 aborts a buffered load to read.
// - Erase: unlock, 80, unlock, then 10 to 555 or 30 to sector.
// - One write of 98 to 55 (word) or AA (byte) enters CFI query.
// - One write of B0 suspends; one write of 30 resumes.
`timescale 1ns/1ps
`include "fcs_regs.svh"

module fcs_host (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 req_valid,
  output logic                      req_ready,
  input  fcs_pkg::fcs_req_t         req,
  input  wire logic                 wr_valid,
  output logic                      wr_ready,
  input  wire logic [23:0]          wr_addr,
  input  wire logic [15:0]          wr_data,
  output logic                      rsp_valid,
  output logic [15:0]               rsp_data,
  output fcs_pkg::fcs_pins_t        flash,
  input  wire logic [15:0]          flash_dq_in
);

  logic                    rst_meta_n;
  logic                    rst_sync_n;
  fcs_pkg::fcs_main_state_t s;
  fcs_pkg::fcs_main_state_t next_s;
  fcs_pkg::fcs_cycle_t     cyc;
  fcs_pkg::fcs_bus_req_t   bus_req;
  logic                    bus_start;
  logic                    bus_idle;
  logic                    bus_done;
  logic [15:0]             bus_rd;

  // Step table: what each bus cycle of a command carries
  function automatic fcs_pkg::fcs_cycle_t seq_step(input fcs_pkg::fcs_cmd_t cmd,
                                                   input logic [2:0]        idx);
    fcs_pkg::fcs_cycle_t c;
    c.kind = (idx == 3'd1 || idx == 3'd4) ? fcs_pkg::K_U2 : fcs_pkg::K_U1;
    c.data = (idx == 3'd1 || idx == 3'd4) ? `FCS_D_UNLOCK2 : `FCS_D_UNLOCK1;
    c.last = 1'b0;
    case (cmd)
      fcs_pkg::CMD_RESET: begin
        c = '{kind: fcs_pkg::K_ANY, data: `FCS_D_RESET, last: 1'b1};
      end
      fcs_pkg::CMD_CFI: begin
        c = '{kind: fcs_pkg::K_CFI, data: `FCS_D_CFI, last: 1'b1};
      end
      fcs_pkg::CMD_SUSPEND: begin
        c = '{kind: fcs_pkg::K_ANY, data: `FCS_D_SUSPEND, last: 1'b1};
      end
      fcs_pkg::CMD_RESUME: begin
        c = '{kind: fcs_pkg::K_ANY, data: `FCS_D_RESUME, last: 1'b1};
      end
      fcs_pkg::CMD_READ, fcs_pkg::CMD_ID_READ: begin
        c = '{kind: fcs_pkg::K_READ, data: 16'h0000, last: 1'b1};
      end
      fcs_pkg::CMD_ID_ENTRY: begin
        if (idx == 3'd2) c = '{kind: fcs_pkg::K_CMD1, data: `FCS_D_AUTOSEL, last: 1'b1};
      end
      fcs_pkg::CMD_SEC_ENTRY: begin
        if (idx == 3'd2) c = '{kind: fcs_pkg::K_CMD1, data: `FCS_D_SECURE, last: 1'b1};
      end
      fcs_pkg::CMD_SEC_EXIT: begin
        if (idx == 3'd2) c = '{kind: fcs_pkg::K_CMD1, data: `FCS_D_AUTOSEL, last: 1'b0};
        if (idx == 3'd3) c = '{kind: fcs_pkg::K_ANY, data: `FCS_D_EXIT, last: 1'b1};
      end
      fcs_pkg::CMD_PROGRAM: begin
        if (idx == 3'd2) c = '{kind: fcs_pkg::K_CMD1, data: `FCS_D_PROGRAM, last: 1'b0};
        if (idx == 3'd3) c = '{kind: fcs_pkg::K_TARGET, data: 16'h0000, last: 1'b1};
      end
      fcs_pkg::CMD_BUF_ABORT: begin
        if (idx == 3'd2) c = '{kind: fcs_pkg::K_CMD1, data: `FCS_D_RESET, last: 1'b1};
      end
      fcs_pkg::CMD_BUF_PROG: begin
        if (idx == 3'd2) c = '{kind: fcs_pkg::K_SECT, data: `FCS_D_BUFLOAD, last: 1'b0};
        if (idx == 3'd3) c = '{kind: fcs_pkg::K_COUNT, data: 16'h0000, last: 1'b0};
        if (idx == 3'd4) c = '{kind: fcs_pkg::K_STREAM, data: 16'h0000, last: 1'b0};
        if (idx == 3'd5) c = '{kind: fcs_pkg::K_SECT, data: `FCS_D_BUFCONF, last: 1'b1};
      end
      fcs_pkg::CMD_CHIP_ERASE, fcs_pkg::CMD_SECT_ERASE: begin
        if (idx == 3'd2) c = '{kind: fcs_pkg::K_CMD1, data: `FCS_D_ERASE, last: 1'b0};
        if (idx == 3'd5) begin
          if (cmd == fcs_pkg::CMD_CHIP_ERASE) begin
            c = '{kind: fcs_pkg::K_CMD1, data: `FCS_D_CHIP, last: 1'b1};
          end else begin
            c = '{kind: fcs_pkg::K_SECT, data: `FCS_D_SECTOR, last: 1'b1};
          end
        end
      end
      default: begin
        c = '{kind: fcs_pkg::K_ANY, data: `FCS_D_RESET, last: 1'b1};
      end
    endcase
    return c;
  endfunction

  // Low offset of each identification item
  function automatic logic [7:0] id_offset(input logic [2:0] sel, input logic byte_mode);
    logic [7:0] o;
    o = `FCS_ID_MAKER_W;
    case (sel)
      3'h1: o = byte_mode ? `FCS_ID_DEV1_B : `FCS_ID_DEV1_W;
      3'h2: o = byte_mode ? `FCS_ID_DEV2_B : `FCS_ID_DEV2_W;
      3'h3: o = byte_mode ? `FCS_ID_DEV3_B : `FCS_ID_DEV3_W;
      3'h4: o = byte_mode ? `FCS_ID_FLOCK_B : `FCS_ID_FLOCK_W;
      3'h5: o = byte_mode ? `FCS_ID_PROT_B : `FCS_ID_PROT_W;
      default: o = byte_mode ? `FCS_ID_MAKER_B : `FCS_ID_MAKER_W;
    endcase
    return o;
  endfunction

  // Reset release through two stages
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  assign cyc       = seq_step(s.cmd, s.idx);
  assign req_ready = (s.st == fcs_pkg::M_IDLE);
  assign wr_ready  = (s.st == fcs_pkg::M_ISSUE) && (cyc.kind == fcs_pkg::K_STREAM);
  // A stream cycle waits for the source, which back-pressures it
  assign bus_start = (s.st == fcs_pkg::M_ISSUE) && bus_idle &&
                     ((cyc.kind != fcs_pkg::K_STREAM) || wr_valid);
  assign rsp_valid = s.rsp_valid;
  assign rsp_data  = s.rsp_data;

  // Address and data of the current cycle; only low bits of unlocks matter
  always_comb begin
    bus_req.read      = (cyc.kind == fcs_pkg::K_READ);
    bus_req.byte_mode = s.byte_mode;
    bus_req.data      = cyc.data;
    bus_req.addr      = `FCS_ANY_ADDR;
    case (cyc.kind)
      fcs_pkg::K_U1, fcs_pkg::K_CMD1: begin
        bus_req.addr = s.byte_mode ? `FCS_UNLOCK1_BYTE : `FCS_UNLOCK1_WORD;
      end
      fcs_pkg::K_U2: begin
        bus_req.addr = s.byte_mode ? `FCS_UNLOCK2_BYTE : `FCS_UNLOCK2_WORD;
      end
      fcs_pkg::K_CFI: begin
        bus_req.addr = s.byte_mode ? `FCS_CFI_BYTE : `FCS_CFI_WORD;
      end
      fcs_pkg::K_SECT, fcs_pkg::K_READ: begin
        bus_req.addr = s.addr;
      end
      fcs_pkg::K_COUNT: begin
        bus_req.addr = s.addr;
        bus_req.data = {11'h000, s.count};
      end
      fcs_pkg::K_TARGET: begin
        bus_req.addr = s.addr;
        bus_req.data = s.data;
      end
      fcs_pkg::K_STREAM: begin
        bus_req.addr = wr_addr;
        bus_req.data = wr_data;
      end
      default: begin
        bus_req.addr = `FCS_ANY_ADDR;
      end
    endcase
  end

  // Command sequencer
  always_comb begin
    next_s           = s;
    next_s.rsp_valid = 1'b0;
    case (s.st)
      fcs_pkg::M_IDLE: begin
        if (req_valid) begin
          next_s.st        = fcs_pkg::M_ISSUE;
          next_s.cmd       = req.cmd;
          next_s.byte_mode = req.byte_mode;
          next_s.addr      = req.addr;
          next_s.data      = req.data;
          next_s.count     = req.count;
          next_s.left      = req.count;
          next_s.idx       = 3'd0;
          // Sector bits come from the caller, low byte is the item offset
          if (req.cmd == fcs_pkg::CMD_ID_READ) begin
            next_s.addr = {req.addr[23:8], id_offset(req.data[2:0], req.byte_mode)};
          end
        end
      end
      fcs_pkg::M_ISSUE: begin
        if (bus_start) begin
          next_s.st = fcs_pkg::M_WAIT;
        end
      end
      fcs_pkg::M_WAIT: begin
        if (bus_done) begin
          if (cyc.kind == fcs_pkg::K_READ) begin
            next_s.rsp_data = bus_rd;
          end
          if (cyc.last) begin
            next_s.st        = fcs_pkg::M_IDLE;
            next_s.rsp_valid = 1'b1;
          end else if (cyc.kind == fcs_pkg::K_STREAM && s.left != 5'h00) begin
            next_s.left = s.left - 5'h01;
            next_s.st   = fcs_pkg::M_ISSUE;
          end else begin
            next_s.idx = s.idx + 3'd1;
            next_s.st  = fcs_pkg::M_ISSUE;
          end
        end
      end
      default: begin
        next_s.st = fcs_pkg::M_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s     <= '0;
      s.st  <= fcs_pkg::M_IDLE;
      s.cmd <= fcs_pkg::CMD_RESET;
    end else begin
      s <= next_s;
    end
  end

  fcs_bus_cycle u_bus (
    .clk     (clk),
    .rst_n   (rst_sync_n),
    .start   (bus_start),
    .req     (bus_req),
    .idle    (bus_idle),
    .done    (bus_done),
    .rd_data (bus_rd),
    .pins    (flash),
    .dq_in   (flash_dq_in)
  );

endmodule

// >>> verif/fcs_host_checker.sv
`timescale 1ns/1ps
module fcs_host_checker (
  input wire logic          clk,
  input wire logic          rst_n,
  input wire logic          req_valid,
  input wire logic          req_ready,
  input fcs_pkg::fcs_req_t  req,
  input wire logic          wr_valid,
  input wire logic          wr_ready,
  input wire logic          rsp_valid,
  input fcs_pkg::fcs_pins_t flash
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Strobe shape of every flash write
  a_we_width: assert property ($fell(flash.we_n) |-> !flash.we_n[*4] ##1 flash.we_n)
    else $error("write strobe width wrong");
  a_ce_setup: assert property ($fell(flash.we_n) |-> $past(flash.ce_n, 2) == 1'b0)
    else $error("chip select setup too short");
  a_ce_hold: assert property ($rose(flash.we_n) |-> !flash.ce_n ##1 !flash.ce_n ##1 flash.ce_n)
    else $error("chip select hold wrong");
  a_no_overlap: assert property (!flash.we_n |-> flash.oe_n && flash.reset_n)
    else $error("write overlaps read or reset");
  // Address and data may not move while the strobe is low
  a_addr_stable: assert property (!flash.we_n ##1 !flash.we_n |-> $stable(flash.addr) && $stable(flash.dq_out))
    else $error("address or data moved in strobe");
  a_drive_write: assert property (!flash.we_n |-> flash.dq_oe == (flash.byte_n ? 16'hFFFF : 16'h80FF))
    else $error("data drivers wrong during write");
  a_bus_release: assert property ($rose(flash.ce_n) |-> flash.dq_oe == 16'h0000)
    else $error("data bus not released");
  a_read_oe: assert property ($fell(flash.oe_n) |-> (!flash.oe_n && flash.dq_oe[14:0] == 15'h0000)[*8])
    else $error("read pulse short or driven");
  // Handshake side of the user interface
  a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer longer than one cycle");
  a_single_len: assert property (req_valid && req_ready && req.cmd == fcs_pkg::CMD_RESET |-> ##[10:12] rsp_valid)
    else $error("single write answer late");
  a_stream_one: assert property (wr_valid && wr_ready |=> !wr_ready)
    else $error("buffer slot taken twice");
endmodule

// >>> verif/fcs_flash_model.sv
`timescale 1ns/1ps
module fcs_flash_model #(
  parameter logic [15:0] MAKER_CODE = 16'h00A5, // Arbitrary value
  parameter logic [15:0] DEV_CODE1  = 16'h1101, // Arbitrary value
  parameter logic [15:0] DEV_CODE2  = 16'h1102, // Arbitrary value
  parameter logic [15:0] DEV_CODE3  = 16'h1103, // Arbitrary value
  parameter int          ACCESS_NS  = 30
) (
  input fcs_pkg::fcs_pins_t pins,
  output logic [15:0]       dq_in
);
  logic [23:0] fa;
  logic [11:0] u1;
  logic [11:0] u2;
  logic [7:0]  d8;
  logic [7:0]  off;
  logic [15:0] rd_val;
  logic [15:0] last_val = 16'h0000;
  logic [1:0]  step = 2'h0;
  logic        id_mode = 1'b0;
  logic        sec_mode = 1'b0;
  logic [23:0] log_addr [0:511];
  logic [15:0] log_data [0:511];
  int          n_wr = 0;

  // Byte mode takes the lowest address bit from DQ15
  assign fa  = pins.byte_n ? {1'b0, pins.addr} : {pins.addr, pins.dq_out[15]};
  assign u1  = pins.byte_n ? 12'h555 : 12'hAAA;
  assign u2  = pins.byte_n ? 12'h2AA : 12'h555;
  assign d8  = pins.dq_out[7:0];
  assign off = pins.byte_n ? fa[7:0] : {1'b0, fa[7:1]};

  // Latch at the rising strobe; only low address bits are decoded
  always @(posedge pins.we_n) begin
    if (!pins.ce_n && pins.reset_n) begin
      log_addr[n_wr] = fa;
      log_data[n_wr] = pins.byte_n ? pins.dq_out : {8'h00, d8};
      n_wr = n_wr + 1;
      if (d8 == 8'hF0) begin
        step = 2'h0;
        id_mode = 1'b0;
      end else if (step == 2'h3 && d8 == 8'h00) begin
        step = 2'h0;
        id_mode = 1'b0;
        sec_mode = 1'b0;
      end else if (d8 == 8'hAA && fa[11:0] == u1) begin
        step = 2'h1;
      end else if (step == 2'h1 && d8 == 8'h55 && fa[11:0] == u2) begin
        step = 2'h2;
      end else if (step == 2'h2 && d8 == 8'h90 && fa[11:0] == u1) begin
        step = 2'h3;
        id_mode = 1'b1;
      end else if (step == 2'h2 && d8 == 8'h88 && fa[11:0] == u1) begin
        step = 2'h0;
        sec_mode = 1'b1;
      end else begin
        step = 2'h0;
        id_mode = 1'b0;
      end
    end
  end

  // Identification table replaces the array while that mode is on
  always_comb begin
    case (off)
      8'h00:   rd_val = MAKER_CODE;
      8'h01:   rd_val = DEV_CODE1;
      8'h0E:   rd_val = DEV_CODE2;
      8'h0F:   rd_val = DEV_CODE3;
      8'h03:   rd_val = 16'h0099;
      8'h02:   rd_val = {15'h0000, fa[16] & fa[17]};
      default: rd_val = 16'h0000;
    endcase
    if (!id_mode) begin
      rd_val = sec_mode ? fa[15:0] ^ 16'h5A5A : ~fa[15:0];
    end
    if (!pins.byte_n) begin
      rd_val = {8'hC3, rd_val[7:0]};
    end
  end

  // Released bus shows the inverse, so a stale sample cannot pass
  assign #(ACCESS_NS) dq_in = (!pins.ce_n && !pins.oe_n) ? rd_val : ~last_val;
  always @(posedge pins.oe_n) begin
    last_val = rd_val;
  end
endmodule

// >>> verif/test_fcs_host.sv
`timescale 1ns/1ps
module test_fcs_host;
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               req_valid = 1'b0;
  fcs_pkg::fcs_req_t  req = '0;
  logic               wr_valid = 1'b0;
  logic [23:0]        wr_addr = 24'h000000;
  logic [15:0]        wr_data = 16'h0000;
  logic               req_ready;
  logic               wr_ready;
  logic               rsp_valid;
  logic [15:0]        rsp_data;
  fcs_pkg::fcs_pins_t flash;
  logic [15:0]        flash_dq_in;
  int                 bad_count = 0;
  int                 cmp_count = 0;
  logic [23:0]        exp_a [$];
  logic [15:0]        exp_d [$];
  bit                 exp_x [$];
  logic               bm = 1'b0;

  // Bench clock
  always #5 clk = ~clk;

  fcs_host uut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
    .wr_data(wr_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .flash(flash),
    .flash_dq_in(flash_dq_in));
  fcs_flash_model dev (.pins(flash), .dq_in(flash_dq_in));

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic add(input bit any, input logic [23:0] a, input logic [15:0] d);
    exp_x.push_back(any);
    exp_a.push_back(a);
    exp_d.push_back(bm ? {8'h00, d[7:0]} : d);
  endtask

  // Request held until taken, then wait for the answer pulse
  task automatic send(input fcs_pkg::fcs_cmd_t c, input logic [23:0] a, input logic [15:0] d,
                      input logic [4:0] n);
    @(negedge clk);
    req_valid = 1'b1;
    req = '{cmd: c, byte_mode: bm, addr: a, data: d, count: n};
    while (req_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1) @(negedge clk);
  endtask

  // Buffer words with a varying stall before each but the first
  task automatic feed(input logic [23:0] a, input logic [4:0] n);
    for (int i = 0; i <= n; i++) begin
      repeat ((i % 3) * 5 + (i > 0 ? 1 : 0)) @(negedge clk);
      wr_valid = 1'b1;
      wr_addr = a + 24'(i);
      wr_data = 16'hC000 + 16'(i);
      while (wr_ready !== 1'b1) @(negedge clk);
      @(negedge clk);
      wr_valid = 1'b0;
    end
  endtask

  // One command, then compare every flash write it made
  task automatic run(input fcs_pkg::fcs_cmd_t c, input logic [23:0] a, input logic [15:0] d,
                     input logic [4:0] n);
    logic [23:0] u1;
    logic [23:0] u2;
    int          base;
    u1 = bm ? 24'h000AAA : 24'h000555;
    u2 = bm ? 24'h000555 : 24'h0002AA;
    base = dev.n_wr;
    exp_a.delete();
    exp_d.delete();
    exp_x.delete();
    case (c)
      fcs_pkg::CMD_RESET:   add(1, 24'h000000, 16'h00F0);
      fcs_pkg::CMD_SUSPEND: add(1, 24'h000000, 16'h00B0);
      fcs_pkg::CMD_RESUME:  add(1, 24'h000000, 16'h0030);
      fcs_pkg::CMD_CFI:     add(0, bm ? 24'h0000AA : 24'h000055, 16'h0098);
      default: begin
        add(0, u1, 16'h00AA);
        add(0, u2, 16'h0055);
      end
    endcase
    case (c)
      fcs_pkg::CMD_ID_ENTRY:  add(0, u1, 16'h0090);
      fcs_pkg::CMD_SEC_ENTRY: add(0, u1, 16'h0088);
      fcs_pkg::CMD_BUF_ABORT: add(0, u1, 16'h00F0);
      fcs_pkg::CMD_SEC_EXIT: begin
        add(0, u1, 16'h0090);
        add(1, 24'h000000, 16'h0000);
      end
      fcs_pkg::CMD_PROGRAM: begin
        add(0, u1, 16'h00A0);
        add(0, a, d);
      end
      fcs_pkg::CMD_CHIP_ERASE, fcs_pkg::CMD_SECT_ERASE: begin
        add(0, u1, 16'h0080);
        add(0, u1, 16'h00AA);
        add(0, u2, 16'h0055);
        if (c == fcs_pkg::CMD_CHIP_ERASE) add(0, u1, 16'h0010);
        else add(0, a, 16'h0030);
      end
      fcs_pkg::CMD_BUF_PROG: begin
        add(0, a, 16'h0025);
        add(0, a, {11'h000, n});
        for (int i = 0; i <= n; i++) add(0, a + 24'(i), 16'hC000 + 16'(i));
        add(0, a, 16'h0029);
      end
      default: ;
    endcase
    if (c == fcs_pkg::CMD_BUF_PROG) begin
      fork
        send(c, a, d, n);
        feed(a, n);
      join
    end else begin
      send(c, a, d, n);
    end
    check("write count", 24'(dev.n_wr - base), 24'(exp_a.size()));
    foreach (exp_a[i]) begin
      if (!exp_x[i]) check("write address", dev.log_addr[base + i], exp_a[i]);
      check("write data", {8'h00, dev.log_data[base + i]}, {8'h00, exp_d[i]});
    end
  endtask

  // Every command sequence except ID entry, buffered program and reads, in both bus widths
  task automatic t_commands();
    fcs_pkg::fcs_cmd_t cl [10] = '{fcs_pkg::CMD_RESET, fcs_pkg::CMD_SUSPEND,
      fcs_pkg::CMD_RESUME, fcs_pkg::CMD_CFI, fcs_pkg::CMD_PROGRAM, fcs_pkg::CMD_BUF_ABORT,
      fcs_pkg::CMD_CHIP_ERASE, fcs_pkg::CMD_SECT_ERASE, fcs_pkg::CMD_SEC_ENTRY,
      fcs_pkg::CMD_SEC_EXIT};
    for (int b = 0; b < 2; b++) begin
      bm = b[0];
      foreach (cl[k]) run(cl[k], 24'h04A5B7, 16'h9A3C, 5'h00);
    end
  endtask

  // Smallest and largest buffer loads, with stalls
  task automatic t_buffer();
    bm = 1'b0;
    run(fcs_pkg::CMD_BUF_PROG, 24'h020000, 16'h0000, 5'h00);
    run(fcs_pkg::CMD_BUF_PROG, 24'h030000, 16'h0000, 5'h1F);
  endtask

  // Identification words in both widths
  task automatic t_ident();
    logic [15:0] tbl [6];
    tbl = '{dev.MAKER_CODE, dev.DEV_CODE1, dev.DEV_CODE2, dev.DEV_CODE3, 16'h0099, 16'h0001};
    for (int b = 0; b < 2; b++) begin
      bm = b[0];
      run(fcs_pkg::CMD_ID_ENTRY, 24'h000000, 16'h0000, 5'h00);
      for (int s = 0; s < 6; s++) begin
        send(fcs_pkg::CMD_ID_READ, 24'h030000, 16'(s), 5'h00);
        check("ident word", rsp_data, bm ? {8'h00, tbl[s][7:0]} : tbl[s]);
      end
      run(fcs_pkg::CMD_RESET, 24'h000000, 16'h0000, 5'h00);
    end
  endtask

  // Security region mapped in and back out; byte read uses A-1
  task automatic t_secure();
    bm = 1'b0;
    send(fcs_pkg::CMD_READ, 24'h001234, 16'h0000, 5'h00);
    check("array read", rsp_data, 16'hEDCB);
    run(fcs_pkg::CMD_SEC_ENTRY, 24'h000000, 16'h0000, 5'h00);
    send(fcs_pkg::CMD_READ, 24'h001234, 16'h0000, 5'h00);
    check("secure read", rsp_data, 16'h486E);
    run(fcs_pkg::CMD_SEC_EXIT, 24'h000000, 16'h0000, 5'h00);
    send(fcs_pkg::CMD_READ, 24'h001234, 16'h0000, 5'h00);
    check("array read again", rsp_data, 16'hEDCB);
    bm = 1'b1;
    send(fcs_pkg::CMD_READ, 24'h000035, 16'h0000, 5'h00);
    check("byte read", rsp_data, 16'h00CA);
  endtask

  // Main sequence
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    check("flash reset pin", flash.reset_n, 1'b1);
    t_commands();
    t_buffer();
    t_ident();
    t_secure();
    results();
  end

  // Watchdog, well beyond the expected run length
  initial begin
    #300000;
    bad_count++;
    results();
  end
endmodule

bind fcs_host fcs_host_checker chk (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
  .req_ready(req_ready), .req(req), .wr_valid(wr_valid), .wr_ready(wr_ready),
  .rsp_valid(rsp_valid), .flash(flash));
